// ---- bench/aism_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// host model on the register port: one request per call, held to its edge
module aism_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // write strobe; address and data turn over once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read strobe; data is taken 1 ns after the edge that samples the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  // clear is a one-shot, no zero write ever follows it
  task automatic clear_latches(input logic [7:0] ctl);
    wr(aism_pkg::ADDR_CTL, ctl | 8'h04);
  endtask
  // inductor bit has to match the fitted part
  task automatic set_inductor(input logic small_part);
    wr(aism_pkg::ADDR_IDLE, {small_part, 7'h48});
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_aism_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb_aism_top;
  logic clk, resetn, wr, rd, th2, th1, hr, boa, ce, ce_ir, ce_fc, ce_rc;
  logic acp, bsrc, cvv, irq, lce, halted, pwr, bridge, byp, idle;
  logic [7:0] addr, wdata, rdata, rd_v, tmp;
  logic [3:0] bol, ratio;
  logic [8:0] unm;
  logic [11:0] bat, stg;
  logic [9:0] rval;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  // rows: write flag, address, write data, expected read
  logic [24:0] rows [21] = '{25'h050_0000, 25'h051_0000, 25'h052_0000,
    25'h053_0000, 25'h054_0000, 25'h055_0000, 25'h056_0000, 25'h05C_0019,
    25'h05D_0080, 25'h060_000D, 25'h063_0048, 25'h15C_FFFB, 25'h15C_1919,
    25'h15D_8C8C, 25'h15D_8080, 25'h160_FD3D, 25'h160_0D0D, 25'h163_C8C8,
    25'h163_4848, 25'h150_FF00, 25'h170_5500};
  logic [9:0] rv [16] = '{10'h010, 10'h018, 10'h020, 10'h030, 10'h040,
    10'h060, 10'h080, 10'h0C0, 10'h100, 10'h180, 10'h200, 10'h07D,
    10'h0FA, 10'h1F4, 10'h000, 10'h000};
  logic [7:0] pats [2] = '{8'hA5, 8'h5A};

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  aism_host host_u (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));

  aism_top #(.HALT_CYC('{20, 40, 60, 80, 100, 120, 140, 160}),
    .IRQ_PULSE_CYC(8), .IRQ_PERIOD_CYC(16)) dut_u (
    .clk(clk), .resetn(resetn), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata),
    .thermal_second_in(th2), .thermal_first_in(th1),
    .headroom_low_in(hr), .brownout_active_in(boa),
    .brownout_level_in(bol), .clock_error_in(ce),
    .clock_error_invalid_ratio_in(ce_ir),
    .clock_error_rate_change_in(ce_fc),
    .clock_error_ratio_change_in(ce_rc), .audio_clock_present_in(acp),
    .brownout_source_select(bsrc), .irq_unmask(unm), .conv_valid(cvv),
    .battery_conversion_code(bat), .stage_supply_conversion_code(stg),
    .temperature_conversion_code(tmp), .interrupt_request_pin(irq),
    .latched_clock_error(lce), .clock_halted(halted),
    .device_power_on(pwr), .bridge_on_stage_supply(bridge),
    .bypass_enable_pad(byp), .fixed_bitclock_ratio(ratio),
    .bitclock_ratio_value(rval), .idle_inductor_select(idle));

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host_u.rd(a, rd_v);
    chk(16'(rd_v), 16'(e));
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // count cycles with the pin at its active-low level
  task automatic count_active(input int k);
    n = 0;
    repeat (k) begin
      @(posedge clk);
      #1;
      if (irq === 1'b0) n++;
    end
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {th2, th1, hr, boa, ce, ce_ir, ce_fc, ce_rc, cvv, bsrc} = '0;
    acp = 1'b1;
    bol = 4'h0;
    unm = 9'h1FF;
    bat = 12'h000;
    stg = 12'h000;
    tmp = 8'h00;
    resetn = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    step(1);
    chk(16'(irq), 16'h0001);
    chk(16'(pwr), 16'h0001);
    chk(16'(bridge), 16'h0000);
    chk(16'(rval), 16'h0030);
    chk(16'(ratio), 16'h0003);
    foreach (rows[i]) begin
      if (rows[i][24]) host_u.wr(rows[i][23:16], rows[i][15:8]);
      rdchk(rows[i][23:16], rows[i][7:0]);
    end
    host_u.set_inductor(1'b1);
    step(1);
    chk(16'(idle), 16'h0001);
    // latched flags stick past their cause until cleared
    foreach (pats[i]) begin
      {th2, th1, hr, boa, bol} = pats[i];
      step(4);
      {th2, th1, hr, boa, bol} = 8'h00;
      step(4);
      rdchk(8'h50, pats[i]);
      chk(16'(irq), 16'h0000);
      host_u.clear_latches(8'h19);
      rdchk(8'h50, 8'h00);
      rdchk(8'h5C, 8'h19);
      chk(16'(irq), 16'h0001);
    end
    // clock error causes
    ce_rc = 1'b1;
    ce = 1'b1;
    step(4);
    {ce, ce_rc} = 2'b00;
    step(4);
    chk(16'(lce), 16'h0001);
    rdchk(8'h51, 8'h03);
    host_u.clear_latches(8'h19);
    {ce, ce_ir, ce_fc} = 3'b111;
    step(4);
    {ce, ce_ir, ce_fc} = 3'b000;
    rdchk(8'h51, 8'h04);
    // conversions captured together, later codes ignored without valid
    bat = 12'hABC;
    stg = 12'h123;
    tmp = 8'h7F;
    cvv = 1'b1;
    step(1);
    bat = 12'h555;
    stg = 12'hFED;
    cvv = 1'b0;
    step(2);
    rdchk(8'h52, 8'hAB);
    rdchk(8'h53, 8'hC0);
    rdchk(8'h54, 8'h12);
    rdchk(8'h55, 8'h30);
    rdchk(8'h56, 8'h7F);
    // every ratio code including the reserved ones
    for (int i = 0; i < 16; i++) begin
      host_u.wr(8'h60, {2'b00, 4'(i), 2'b01});
      step(2);
      chk(16'(ratio), 16'(i));
      chk(16'(rval), 16'(rv[i]));
    end
    host_u.wr(8'h60, 8'h0D);
    // bridge switch level against each level select code
    for (int c = 0; c < 4; c++) begin
      host_u.wr(8'h5D, {4'h8, 2'(c), 2'b00});
      for (int l = 0; l < 4; l++) begin
        bol = 4'(1 << l);
        step(4);
        chk(16'(bridge), 16'(l <= c));
        chk(16'(byp), 16'(l <= c));
        bol = 4'h0;
        step(4);
      end
    end
    // a supply-side brownout source never moves the bridge
    bsrc = 1'b1;
    bol = 4'h1;
    step(4);
    chk(16'(bridge), 16'h0000);
    chk(16'(byp), 16'h0000);
    bol = 4'h0;
    bsrc = 1'b0;
    host_u.wr(8'h5D, 8'h00);
    step(2);
    chk(16'(irq), 16'h0001);
    host_u.wr(8'h5D, 8'h80);
    host_u.clear_latches(8'h18);
    // live mode follows the condition, not the latch
    th1 = 1'b1;
    step(4);
    chk(16'(irq), 16'h0000);
    th1 = 1'b0;
    step(4);
    chk(16'(irq), 16'h0001);
    host_u.wr(8'h5C, 8'h19);
    step(2);
    chk(16'(irq), 16'h0000);
    unm = 9'h000;
    step(3);
    chk(16'(irq), 16'h0001);
    unm = 9'h1FF;
    host_u.wr(8'h5C, 8'h1B);
    step(20);
    count_active(32);
    chk(16'(n), 16'h0010);
    host_u.clear_latches(8'h1A);
    th2 = 1'b1;
    count_active(40);
    chk(16'(n), 16'h0009);
    th2 = 1'b0;
    // clock halt watch with timer code one
    host_u.clear_latches(8'h89);
    step(4);
    chk(16'(pwr), 16'h0001);
    {acp, ce} = 2'b01;
    step(30);
    chk(16'(halted), 16'h0000);
    step(20);
    chk(16'(halted), 16'h0001);
    chk(16'(pwr), 16'h0000);
    {acp, ce} = 2'b10;
    step(5);
    chk(16'(halted), 16'h0000);
    chk(16'(pwr), 16'h0001);
    host_u.wr(8'h5C, 8'hC9);
    {acp, ce} = 2'b01;
    step(60);
    chk(16'(halted), 16'h0000);
    chk(16'(pwr), 16'h0000);
    {acp, ce} = 2'b10;
    step(2);
    // reset in mid-run returns registers and latches to their defaults
    resetn = 1'b0;
    step(2);
    resetn = 1'b1;
    step(1);
    chk(16'(irq), 16'h0001);
    chk(16'(pwr), 16'h0001);
    rdchk(8'h51, 8'h00);
    rdchk(8'h5C, 8'h19);
    test_done();
  end
endmodule
`default_nettype wire

// ---- rtl/aism_pkg.sv ----
package aism_pkg;
  // register offsets
  localparam logic [7:0] ADDR_LATCH = 8'h50;
  localparam logic [7:0] ADDR_CETYPE = 8'h51;
  localparam logic [7:0] ADDR_BAT_HI = 8'h52;
  localparam logic [7:0] ADDR_BAT_LO = 8'h53;
  localparam logic [7:0] ADDR_STG_HI = 8'h54;
  localparam logic [7:0] ADDR_STG_LO = 8'h55;
  localparam logic [7:0] ADDR_TEMP = 8'h56;
  localparam logic [7:0] ADDR_CTL = 8'h5C;
  localparam logic [7:0] ADDR_POL = 8'h5D;
  localparam logic [7:0] ADDR_RATIO = 8'h60;
  localparam logic [7:0] ADDR_IDLE = 8'h63;
  // reset values
  localparam logic [7:0] CTL_RST = 8'h19;
  localparam logic [7:0] POL_RST = 8'h80;
  localparam logic [7:0] RATIO_RST = 8'h0D;
  localparam logic [7:0] IDLE_RST = 8'h48;
  // field positions
  localparam int CTL_PWR_BIT = 7;
  localparam int CTL_HDIS_BIT = 6;
  localparam int CTL_TMR_LSB = 3;
  localparam int CTL_CLR_BIT = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int POL_BIT = 7;
  localparam int BSW_LSB = 2;
  localparam int RATIO_LSB = 2;
  localparam int IDLE_BIT = 7;
  localparam int CE_IR_BIT = 2;
  localparam int CE_FC_BIT = 1;
  localparam int CE_RC_BIT = 0;
  // pin modes
  localparam logic [1:0] MODE_LIVE = 2'h0;
  localparam logic [1:0] MODE_LATCH = 2'h1;
  localparam logic [1:0] MODE_ONCE = 2'h2;
  localparam logic [1:0] MODE_REPEAT = 2'h3;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned HALT_NS [8] = '{820_000, 3_270_000,
    26_210_000, 52_420_000, 104_850_000, 209_710_000,
    419_430_000, 838_860_000};
  localparam int unsigned IRQ_PULSE_NS = 2_000_000;
  localparam int unsigned IRQ_PERIOD_NS = 4_000_000;
  localparam int TMR_W = 26;

  // least time in whole clock cycles
  function automatic int unsigned cyc_up(input int unsigned ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  // bit-clock per frame for a ratio code, zero when reserved
  function automatic logic [9:0] ratio_of(input logic [3:0] c);
    logic [9:0] r;
    r = 10'h000;
    case (c)
      4'h0: r = 10'd16;
      4'h1: r = 10'd24;
      4'h2: r = 10'd32;
      4'h3: r = 10'd48;
      4'h4: r = 10'd64;
      4'h5: r = 10'd96;
      4'h6: r = 10'd128;
      4'h7: r = 10'd192;
      4'h8: r = 10'd256;
      4'h9: r = 10'd384;
      4'hA: r = 10'd512;
      4'hB: r = 10'd125;
      4'hC: r = 10'd250;
      4'hD: r = 10'd500;
      default: r = 10'h000;
    endcase
    return r;
  endfunction
endpackage

// ---- rtl/aism_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for pin levels
module aism_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/aism_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
// up-counter that stops at its limit
module aism_timer #(
  parameter int W = 26
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic run,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic expired
);
  assign expired = (count >= limit);

  // clear has priority over counting
  always_ff @(posedge clk) begin
    if (!resetn || clear) begin
      count <= '0;
    end else if (run && !expired) begin
      count <= count + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/aism_top.sv ----
`timescale 1ns/100ps
`default_nettype none
// fault latches, readback and interrupt pin shaping
module aism_top #(
  parameter int unsigned HALT_CYC [8] = '{
    aism_pkg::cyc_up(aism_pkg::HALT_NS[0]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[1]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[2]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[3]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[4]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[5]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[6]),
    aism_pkg::cyc_up(aism_pkg::HALT_NS[7])},
  parameter int unsigned IRQ_PULSE_CYC =
    aism_pkg::cyc_up(aism_pkg::IRQ_PULSE_NS),
  parameter int unsigned IRQ_PERIOD_CYC =
    aism_pkg::IRQ_PERIOD_NS / aism_pkg::CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic thermal_second_in,
  input wire logic thermal_first_in,
  input wire logic headroom_low_in,
  input wire logic brownout_active_in,
  input wire logic [3:0] brownout_level_in,
  input wire logic clock_error_in,
  input wire logic clock_error_invalid_ratio_in,
  input wire logic clock_error_rate_change_in,
  input wire logic clock_error_ratio_change_in,
  input wire logic audio_clock_present_in,
  input wire logic brownout_source_select,
  input wire logic [8:0] irq_unmask,
  input wire logic conv_valid,
  input wire logic [11:0] battery_conversion_code,
  input wire logic [11:0] stage_supply_conversion_code,
  input wire logic [7:0] temperature_conversion_code,
  output logic interrupt_request_pin,
  output logic latched_clock_error,
  output logic clock_halted,
  output logic device_power_on,
  output logic bridge_on_stage_supply,
  output logic bypass_enable_pad,
  output logic [3:0] fixed_bitclock_ratio,
  output logic [9:0] bitclock_ratio_value,
  output logic idle_inductor_select
);
  localparam int W = aism_pkg::TMR_W;

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_WATCH,
    HS_HALTED
  } aism_halt_t;

  //////////////////////////////////////////////////////////////////////
  // pin inputs through synchronisers
  logic [12:0] pins_s;
  logic [7:0] lt3_set;
  logic ce_s, ce_ir_s, ce_fc_s, ce_rc_s, clk_ok_s;

  aism_sync #(.W(13)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .d({thermal_second_in, thermal_first_in, headroom_low_in,
        brownout_active_in, brownout_level_in, clock_error_in,
        clock_error_invalid_ratio_in, clock_error_rate_change_in,
        clock_error_ratio_change_in, audio_clock_present_in}),
    .q(pins_s)
  );

  assign lt3_set = pins_s[12:5];
  assign ce_s = pins_s[4];
  assign ce_ir_s = pins_s[3];
  assign ce_fc_s = pins_s[2];
  assign ce_rc_s = pins_s[1];
  assign clk_ok_s = pins_s[0];

  //////////////////////////////////////////////////////////////////////
  // register decode
  logic [7:0] ctl_r, pol_r, ratio_r, idle_r;
  logic wr_ctl, wr_pol, wr_ratio, wr_idle, clr_cmd;
  logic [1:0] irq_mode;
  logic [2:0] halt_sel;
  logic [1:0] bsw_sel;

  assign wr_ctl = reg_wr && (reg_addr == aism_pkg::ADDR_CTL);
  assign wr_pol = reg_wr && (reg_addr == aism_pkg::ADDR_POL);
  assign wr_ratio = reg_wr && (reg_addr == aism_pkg::ADDR_RATIO);
  assign wr_idle = reg_wr && (reg_addr == aism_pkg::ADDR_IDLE);
  assign clr_cmd = wr_ctl && reg_wdata[aism_pkg::CTL_CLR_BIT];
  assign irq_mode = ctl_r[aism_pkg::CTL_MODE_LSB +: 2];
  assign halt_sel = ctl_r[aism_pkg::CTL_TMR_LSB +: 3];
  assign bsw_sel = pol_r[aism_pkg::BSW_LSB +: 2];

  // writable registers; the clear bit is never stored
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctl_r <= aism_pkg::CTL_RST;
      pol_r <= aism_pkg::POL_RST;
      ratio_r <= aism_pkg::RATIO_RST;
      idle_r <= aism_pkg::IDLE_RST;
    end else begin
      if (wr_ctl) begin
        ctl_r <= reg_wdata & ~(8'h01 << aism_pkg::CTL_CLR_BIT);
      end
      if (wr_pol) begin
        pol_r <= reg_wdata;
      end
      if (wr_ratio) begin
        ratio_r <= {2'b00, reg_wdata[5:0]};
      end
      if (wr_idle) begin
        idle_r <= reg_wdata;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // sticky latches, set beats clear
  logic [7:0] lt3_r, lt3_nxt;
  logic [2:0] cet_r, cet_nxt, cet_set;
  logic lce_r, lce_nxt;

  assign cet_set[aism_pkg::CE_IR_BIT] = ce_s && ce_ir_s;
  assign cet_set[aism_pkg::CE_FC_BIT] = ce_s && !ce_fc_s;
  assign cet_set[aism_pkg::CE_RC_BIT] = ce_s && ce_rc_s;
  assign lt3_nxt = (lt3_r & {8{!clr_cmd}}) | lt3_set;
  assign cet_nxt = (cet_r & {3{!clr_cmd}}) | cet_set;
  assign lce_nxt = (lce_r && !clr_cmd) || ce_s;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      lt3_r <= 8'h00;
      cet_r <= 3'h0;
      lce_r <= 1'b0;
    end else begin
      lt3_r <= lt3_nxt;
      cet_r <= cet_nxt;
      lce_r <= lce_nxt;
    end
  end

  assign latched_clock_error = lce_r;

  //////////////////////////////////////////////////////////////////////
  // conversion results captured whole
  logic [11:0] bat_r, stg_r;
  logic [7:0] tmp_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      bat_r <= 12'h000;
      stg_r <= 12'h000;
      tmp_r <= 8'h00;
    end else if (conv_valid) begin
      bat_r <= battery_conversion_code;
      stg_r <= stage_supply_conversion_code;
      tmp_r <= temperature_conversion_code;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read multiplexer, unmapped reads give zero
  logic [7:0] rd_sel;

  assign rd_sel =
    (reg_addr == aism_pkg::ADDR_LATCH) ? lt3_r :
    (reg_addr == aism_pkg::ADDR_CETYPE) ? {5'h00, cet_r} :
    (reg_addr == aism_pkg::ADDR_BAT_HI) ? bat_r[11:4] :
    (reg_addr == aism_pkg::ADDR_BAT_LO) ? {bat_r[3:0], 4'h0} :
    (reg_addr == aism_pkg::ADDR_STG_HI) ? stg_r[11:4] :
    (reg_addr == aism_pkg::ADDR_STG_LO) ? {stg_r[3:0], 4'h0} :
    (reg_addr == aism_pkg::ADDR_TEMP) ? tmp_r :
    (reg_addr == aism_pkg::ADDR_CTL) ? ctl_r :
    (reg_addr == aism_pkg::ADDR_POL) ? pol_r :
    (reg_addr == aism_pkg::ADDR_RATIO) ? ratio_r :
    (reg_addr == aism_pkg::ADDR_IDLE) ? idle_r : 8'h00;

  // read data held until the next read
  always_ff @(posedge clk) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_sel;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // clock-halt watch after a clock error
  aism_halt_t hs_r, hs_nxt;
  logic ce_d_r, ce_rise, halt_exp;
  logic [W-1:0] halt_cnt, halt_lim;

  assign ce_rise = ce_s && !ce_d_r;
  assign halt_lim = W'(HALT_CYC[halt_sel]);

  always_comb begin
    hs_nxt = hs_r;
    case (hs_r)
      HS_IDLE: begin
        if (ce_rise && !ctl_r[aism_pkg::CTL_HDIS_BIT]) begin
          hs_nxt = HS_WATCH;
        end
      end
      HS_WATCH: begin
        if (ctl_r[aism_pkg::CTL_HDIS_BIT]) begin
          hs_nxt = HS_IDLE;
        end else if (halt_exp) begin
          hs_nxt = HS_HALTED;
        end
      end
      HS_HALTED: begin
        if (clk_ok_s) begin
          hs_nxt = HS_IDLE;
        end
      end
      default: hs_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      hs_r <= HS_IDLE;
      ce_d_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      ce_d_r <= ce_s;
    end
  end

  // timer runs only while the audio clock is absent
  aism_timer #(.W(W)) u_halt_tmr (
    .clk(clk),
    .resetn(resetn),
    .clear(hs_r != HS_WATCH || clk_ok_s),
    .run(1'b1),
    .limit(halt_lim),
    .count(halt_cnt),
    .expired(halt_exp)
  );

  assign clock_halted = (hs_r == HS_HALTED);

  //////////////////////////////////////////////////////////////////////
  // interrupt pin shaping
  logic [8:0] live_vec, lat_vec;
  logic live_any, lat_any, live_d_r, once_r, act, irq_exp, irq_clr;
  logic [W-1:0] irq_cnt, irq_lim;

  assign live_vec = {lt3_set, ce_s} & irq_unmask;
  assign lat_vec = {lt3_r, lce_r} & irq_unmask;
  assign live_any = |live_vec;
  assign lat_any = |lat_vec;
  assign irq_lim = (irq_mode == aism_pkg::MODE_REPEAT) ?
    W'(IRQ_PERIOD_CYC - 1) : W'(IRQ_PULSE_CYC);
  assign irq_clr = (irq_mode == aism_pkg::MODE_REPEAT) ?
    (!lat_any || irq_exp) : !once_r;

  aism_timer #(.W(W)) u_irq_tmr (
    .clk(clk),
    .resetn(resetn),
    .clear(irq_clr),
    .run(1'b1),
    .limit(irq_lim),
    .count(irq_cnt),
    .expired(irq_exp)
  );

  // mode selects the raw request
  assign act =
    (irq_mode == aism_pkg::MODE_LIVE) ? live_any :
    (irq_mode == aism_pkg::MODE_LATCH) ? lat_any :
    (irq_mode == aism_pkg::MODE_ONCE) ? once_r :
    (lat_any && irq_cnt < W'(IRQ_PULSE_CYC));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      live_d_r <= 1'b0;
      once_r <= 1'b0;
      interrupt_request_pin <= 1'b1;
    end else begin
      live_d_r <= live_any;
      if (irq_mode != aism_pkg::MODE_ONCE || (once_r && irq_exp)) begin
        once_r <= 1'b0;
      end else if (live_any && !live_d_r) begin
        once_r <= 1'b1;
      end
      interrupt_request_pin <= act ^ pol_r[aism_pkg::POL_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // power, bridge supply and ratio outputs
  logic [3:0] bsw_mask;
  logic bsw_hit;

  assign bsw_mask = 4'hF >> (2'd3 - bsw_sel);
  assign bsw_hit = !brownout_source_select &&
    |(lt3_set[3:0] & bsw_mask);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      device_power_on <= 1'b1;
      bridge_on_stage_supply <= 1'b0;
      bypass_enable_pad <= 1'b0;
      bitclock_ratio_value <= 10'h000;
    end else begin
      device_power_on <= !ctl_r[aism_pkg::CTL_PWR_BIT] ||
        (clk_ok_s && hs_r != HS_HALTED);
      bridge_on_stage_supply <= bsw_hit;
      bypass_enable_pad <= bsw_hit;
      bitclock_ratio_value <= aism_pkg::ratio_of(fixed_bitclock_ratio);
    end
  end

  assign fixed_bitclock_ratio = ratio_r[aism_pkg::RATIO_LSB +: 4];
  assign idle_inductor_select = idle_r[aism_pkg::IDLE_BIT];

  //////////////////////////////////////////////////////////////////////
  // assertions
  property p_lt3_set;
    @(posedge clk) disable iff (!resetn)
    (lt3_set != 8'h00) |=> ((lt3_r & $past(lt3_set)) == $past(lt3_set));
  endproperty
  a_lt3_set: assert property (p_lt3_set) else $error("flag not set");

  property p_sticky;
    @(posedge clk) disable iff (!resetn)
    !clr_cmd |=> ((lt3_r & $past(lt3_r)) == $past(lt3_r));
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
    (clr_cmd && lt3_set == 8'h00 && !ce_s) |=> (lt3_r == 8'h00 && !lce_r);
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed");

  property p_selfclr;
    @(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == aism_pkg::ADDR_CTL) |=> !reg_rdata[2];
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("clr bit kept");

  property p_cetype;
    @(posedge clk) disable iff (!resetn)
    (ce_s && !ce_fc_s && ce_rc_s) |=> (cet_r[1] && cet_r[0] && lce_r);
  endproperty
  a_cetype: assert property (p_cetype) else $error("type wrong");

  property p_bat_lo;
    @(posedge clk) disable iff (!resetn)
    (reg_rd && reg_addr == aism_pkg::ADDR_BAT_LO && !conv_valid) |=>
      (reg_rdata == {bat_r[3:0], 4'h0});
  endproperty
  a_bat_lo: assert property (p_bat_lo) else $error("bat lsb bad");

  property p_conv;
    @(posedge clk) disable iff (!resetn)
    conv_valid |=> (stg_r == $past(stage_supply_conversion_code) &&
      tmp_r == $past(temperature_conversion_code));
  endproperty
  a_conv: assert property (p_conv) else $error("conv not whole");

  property p_pin_latch;
    @(posedge clk) disable iff (!resetn)
    (irq_mode == aism_pkg::MODE_LATCH && lat_any) |=>
      (interrupt_request_pin == !$past(pol_r[7]));
  endproperty
  a_pin_latch: assert property (p_pin_latch) else $error("pin bad");

  property p_halt;
    @(posedge clk) disable iff (!resetn)
    (hs_r == HS_WATCH && halt_exp && !ctl_r[6]) |=> clock_halted;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");

  property p_bridge;
    @(posedge clk) disable iff (!resetn)
    (!brownout_source_select && lt3_set[0]) |=> bridge_on_stage_supply;
  endproperty
  a_bridge: assert property (p_bridge) else $error("no switch");

  property p_pwr;
    @(posedge clk) disable iff (!resetn)
    !ctl_r[7] |=> device_power_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("power off");

  c_clear: cover property (@(posedge clk) clr_cmd && lt3_r != 8'h00);
  c_halt: cover property (@(posedge clk) hs_r == HS_HALTED);
  c_once: cover property (@(posedge clk) once_r && irq_exp);
endmodule
`default_nettype wire
